// [hw/rmc_port.sv]
// Host command port of the radio modem: parser, modes, buffers, responses
// Notes on behaviour
// RULE1 - Command: 40h, two letters, parameters, 0Dh
// RULE2 - Response opens with asterisk and command name
// RULE3 - Then equals, value bytes, closing 0Dh 0Ah
// RULE4 - Exactly one response or error per command
// RULE5 - Host waits for response before next command
// RULE6 - RTS low when accepting, high when full
// RULE7 - Serial output only while CTS low
// RULE8 - Binary mode: mode command, pin low; pin high exits
// RULE9 - Text mode: mode command, pin low; pin high exits
// RULE10 - Escape byte 1Bh leaves text mode
// RULE11 - Commands ignored for 100 ms after power-up
// RULE12 - Errored radio frames dropped without any report
// RULE13 - Send count is two hex digits, echoed
// RULE14 - Two alternating 255-byte send buffers
// RULE15 - Receive by default, transmit when buffer loaded
// RULE16 - Continuous transmit window 5 ms plus 2.08 ms/byte
// RULE17 - Reports named data, variant c or variant s
// RULE18 - Air bit rate fixed at 4800 bps
// RULE19 - Relayed frames forwarded, never reported to host
// RULE20 - Host should prefer acknowledged send variant
// RULE21 - Host resyncs on CR LF and next asterisk
`timescale 1ns/1ps
`default_nettype none
`include "rmc_defs.svh"

module rmc_port #(
  parameter int DEPTH    = `RMC_BUF_DEPTH,
  parameter int BOOT_CYC = `RMC_BOOT_CYC,
  parameter int WIN_BASE = `RMC_WIN_BASE_CYC,
  parameter int WIN_BYTE = `RMC_WIN_BYTE_CYC,
  parameter int AIR_DIV  = `RMC_AIR_DIV
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             nrst,
  // Host serial bytes (UART on this clock)
  input  wire logic             rx_valid,
  input  wire logic [7:0]       rx_data,
  output logic                  ser_tx_valid,
  output logic [7:0]            ser_tx_data,
  input  wire logic             ser_tx_ready,
  // Host pins
  output logic                  rts_n,
  input  wire logic             cts_n,
  input  wire logic             mode_pin,
  // Radio receive side
  input  wire logic             rf_rx_valid,
  input  wire rmc_pkg::rmc_rfi_s rf_rx,
  output logic                  rf_rx_ack,
  output logic                  relay_fwd,
  output logic [7:0]            rf_rd_idx,
  input  wire logic [7:0]       rf_rd_data,
  // Radio transmit side
  output logic                  rf_tx_start,
  output logic                  rf_tx_sel,
  output logic [7:0]            rf_tx_len,
  input  wire logic [7:0]       rf_tx_rd_idx,
  output logic [7:0]            rf_tx_data,
  input  wire logic             rf_tx_done,
  output logic                  tx_mode,
  output logic                  air_tick
);

  // Hex digit helpers
  function automatic logic hex_ok(input logic [7:0] c);
    return (c >= 8'h30 && c <= 8'h39) || (c >= 8'h41 && c <= 8'h46)
        || (c >= 8'h61 && c <= 8'h66);
  endfunction
  function automatic logic [3:0] hex_val(input logic [7:0] c);
    return (c <= 8'h39) ? c[3:0] : 4'(c[3:0] + 4'h9);
  endfunction
  function automatic logic [7:0] hex_chr(input logic [3:0] n);
    return (n < 4'ha) ? 8'h30 + {4'h0, n} : 8'h37 + {4'h0, n};
  endfunction

  // Pin synchronisers and edge history
  logic cts_s1_q, cts_s2_q, mode_s1_q, mode_s2_q, mode_d_q;
  // Blackout, mode and parser state
  logic [21:0]        boot_cnt_q;
  logic               boot_q;
  rmc_pkg::rmc_mode_e mode_q, pend_q;
  rmc_pkg::rmc_pst_e  pst_q;
  logic [7:0]         n0_q, n1_q, cnt_q, widx_q;
  logic [3:0][7:0]    val_q;
  logic [2:0]         nval_q;
  logic               hi_q, bad_q, cmd_req_q;
  // Send buffers and radio launcher
  logic [7:0]         buf_q [2][DEPTH];
  logic [1:0]         loaded_q;
  logic [7:0]         blen_q [2];
  logic               fptr_q, lptr_q, busy_q;
  logic [23:0]        win_q;
  logic [12:0]        air_cnt_q;
  // Response emitter
  rmc_pkg::rmc_rsp_s  rsp_q;
  logic               act_q, is_cmd_q, gap_q;
  logic [8:0]         pos_q;

  // Shared combinational terms
  logic       rx_ok, dctl, wr_en, commit, mode_rise, cmd_take, cmd_busy;
  logic [7:0] c_len, obyte;
  logic [8:0] last, dpos;

  assign rx_ok     = rx_valid && !boot_q; // [RULE11]
  assign mode_rise = mode_s2_q && !mode_d_q;
  assign dctl      = mode_q == rmc_pkg::M_TXT
                  && (rx_data == `RMC_CH_CR || rx_data == `RMC_CH_ESC);
  assign cmd_take  = !act_q && cmd_req_q;
  assign cmd_busy  = cmd_req_q || (act_q && is_cmd_q);

  // Payload lands in the buffer the fill pointer names, never a loaded one
  assign wr_en = rx_ok && !loaded_q[fptr_q]
              && ((mode_q == rmc_pkg::M_CMD && pst_q == rmc_pkg::P_PAY)
               || (mode_q != rmc_pkg::M_CMD && !dctl)); // [RULE14]
  // Hand a buffer to the radio at the send line's CR, or in data modes
  always_comb begin
    commit = 1'b0;
    c_len  = cnt_q;
    if (mode_q == rmc_pkg::M_CMD) begin
      commit = rx_ok && pst_q == rmc_pkg::P_END && rx_data == `RMC_CH_CR
            && !bad_q;
    end else begin
      c_len  = wr_en ? widx_q + 8'h01 : widx_q;
      commit = (wr_en && widx_q == 8'(DEPTH - 1))
            || (widx_q != 8'h00 && ((rx_ok && dctl) || mode_rise));
    end
  end

  // Two-flop synchronisers; idle high so nothing moves before sampling
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cts_s1_q  <= 1'b1;
      cts_s2_q  <= 1'b1;
      mode_s1_q <= 1'b1;
      mode_s2_q <= 1'b1;
      mode_d_q  <= 1'b1;
    end else begin
      cts_s1_q  <= cts_n;
      cts_s2_q  <= cts_s1_q;
      mode_s1_q <= mode_pin;
      mode_s2_q <= mode_s1_q;
      mode_d_q  <= mode_s2_q;
    end
  end

  // Power-up blackout
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      boot_cnt_q <= 22'h000000;
      boot_q     <= 1'b1;
    end else if (boot_q) begin
      boot_cnt_q <= boot_cnt_q + 22'h000001;
      if (boot_cnt_q == 22'(BOOT_CYC - 1)) boot_q <= 1'b0; // [RULE11]
    end
  end

  // Mode switching; pin high always wins back command mode
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mode_q <= rmc_pkg::M_CMD;
      pend_q <= rmc_pkg::M_CMD;
    end else begin
      if (mode_s2_q) begin
        mode_q <= rmc_pkg::M_CMD; // [RULE8] [RULE9]
      end else if (mode_d_q && pend_q != rmc_pkg::M_CMD) begin
        mode_q <= pend_q; // Falling pin after the mode command
        pend_q <= rmc_pkg::M_CMD;
      end else if (mode_q == rmc_pkg::M_TXT && rx_ok
                   && rx_data == `RMC_CH_ESC) begin
        mode_q <= rmc_pkg::M_CMD; // [RULE10]
      end
      if (rx_ok && mode_q == rmc_pkg::M_CMD && pst_q == rmc_pkg::P_ARG
          && rx_data == `RMC_CH_CR && n0_q == `RMC_CH_M
          && n1_q == `RMC_CH_D && nval_q == 3'h2) begin
        if (val_q[0] == `RMC_CH_B && val_q[1] == `RMC_CH_I)
          pend_q <= rmc_pkg::M_BIN; // [RULE8]
        else if (val_q[0] == `RMC_CH_T && val_q[1] == `RMC_CH_X)
          pend_q <= rmc_pkg::M_TXT; // [RULE9]
      end
    end
  end

  // Command line parser; a CR anywhere in a line except the payload ends it with a response
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pst_q     <= rmc_pkg::P_IDLE;
      n0_q      <= 8'h00;
      n1_q      <= 8'h00;
      val_q     <= '0;
      nval_q    <= 3'h0;
      cnt_q     <= 8'h00;
      hi_q      <= 1'b0;
      bad_q     <= 1'b0;
      cmd_req_q <= 1'b0;
      widx_q    <= 8'h00;
    end else begin
      if (cmd_take) cmd_req_q <= 1'b0;
      // Write index follows payload and resets on hand-over
      if (commit) widx_q <= 8'h00;
      else if (wr_en) widx_q <= widx_q + 8'h01;
      if (rx_ok && mode_q == rmc_pkg::M_CMD) begin
        if (pst_q != rmc_pkg::P_IDLE && pst_q != rmc_pkg::P_PAY
            && rx_data == `RMC_CH_CR) begin
          pst_q     <= rmc_pkg::P_IDLE;
          cmd_req_q <= 1'b1; // [RULE4]
          // Short lines or a missing count earn an error response
          if (pst_q == rmc_pkg::P_N0 || pst_q == rmc_pkg::P_N1
              || pst_q == rmc_pkg::P_CNT
              || (pst_q == rmc_pkg::P_SEP && cnt_q != 8'h00))
            bad_q <= 1'b1;
        end else begin
          case (pst_q)
            rmc_pkg::P_IDLE: begin
              // Prefix opens a line; refused while a response is owed
              if (rx_data == `RMC_CH_PFX && !cmd_busy) begin // [RULE1] [RULE5]
                pst_q  <= rmc_pkg::P_N0;
                nval_q <= 3'h0;
                bad_q  <= 1'b0;
                hi_q   <= 1'b0;
                cnt_q  <= 8'h00;
              end
            end
            rmc_pkg::P_N0: begin
              n0_q  <= rx_data;
              pst_q <= rmc_pkg::P_N1;
            end
            rmc_pkg::P_N1: begin
              n1_q  <= rx_data;
              pst_q <= (n0_q == `RMC_CH_D && rx_data == `RMC_CH_T)
                     ? rmc_pkg::P_CNT : rmc_pkg::P_ARG;
            end
            rmc_pkg::P_ARG: begin
              // Keep up to four argument characters for the echo
              if (rx_data != `RMC_CH_SP && nval_q < 3'h4) begin
                val_q[nval_q[1:0]] <= rx_data;
                nval_q <= nval_q + 3'h1;
              end
            end
            rmc_pkg::P_CNT: begin
              if (rx_data == `RMC_CH_SP && !hi_q) begin
                // Leading blank before the count
              end else if (!hex_ok(rx_data)) begin
                bad_q <= 1'b1;
                pst_q <= rmc_pkg::P_END;
              end else begin
                cnt_q <= {cnt_q[3:0], hex_val(rx_data)}; // [RULE13]
                val_q[nval_q[1:0]] <= rx_data; // Echoed count
                nval_q <= nval_q + 3'h1;
                hi_q   <= 1'b1;
                if (hi_q) pst_q <= rmc_pkg::P_SEP;
              end
            end
            rmc_pkg::P_SEP: begin
              // One blank between count and payload; no free buffer is an error
              if (rx_data != `RMC_CH_SP || loaded_q[fptr_q]) bad_q <= 1'b1;
              pst_q <= (cnt_q == 8'h00) ? rmc_pkg::P_END : rmc_pkg::P_PAY;
            end
            rmc_pkg::P_PAY: begin
              // Exactly the counted bytes, CR included if sent
              if (widx_q == cnt_q - 8'h01) pst_q <= rmc_pkg::P_END;
            end
            rmc_pkg::P_END: begin
              bad_q <= 1'b1; // Anything but CR after the payload
            end
            default: pst_q <= rmc_pkg::P_IDLE;
          endcase
        end
      end
    end
  end

  // Buffer storage, no reset needed for data
  always_ff @(posedge clk) begin
    if (wr_en) buf_q[fptr_q][widx_q] <= rx_data; // [RULE14]
    rf_tx_data <= buf_q[rf_tx_sel][rf_tx_rd_idx];
  end

  // Buffer ownership and radio launch, alternating to keep order
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      loaded_q    <= 2'b00;
      blen_q      <= '{8'h00, 8'h00};
      fptr_q      <= 1'b0;
      lptr_q      <= 1'b0;
      busy_q      <= 1'b0;
      rf_tx_start <= 1'b0;
      rf_tx_sel   <= 1'b0;
      rf_tx_len   <= 8'h00;
    end else begin
      rf_tx_start <= 1'b0;
      if (commit) begin
        loaded_q[fptr_q] <= 1'b1;
        blen_q[fptr_q]   <= c_len;
        fptr_q           <= !fptr_q; // [RULE14]
      end
      if (busy_q && rf_tx_done) begin
        loaded_q[lptr_q] <= 1'b0;
        busy_q           <= 1'b0;
        lptr_q           <= !lptr_q;
      end else if (!busy_q && loaded_q[lptr_q]) begin
        busy_q      <= 1'b1;
        rf_tx_start <= 1'b1; // [RULE15]
        rf_tx_sel   <= lptr_q;
        rf_tx_len   <= blen_q[lptr_q];
      end
    end
  end

  // Continuous window, then back to receive
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      win_q   <= 24'h000000;
      tx_mode <= 1'b0; // [RULE15]
    end else begin
      if (commit)
        win_q <= 24'(WIN_BASE) + 24'(WIN_BYTE) * {16'h0000, c_len}; // [RULE16]
      else if (win_q != 24'h000000)
        win_q <= win_q - 24'h000001;
      if (!busy_q && loaded_q[lptr_q])
        tx_mode <= 1'b1;
      else if (!busy_q && loaded_q == 2'b00 && win_q == 24'h000000)
        tx_mode <= 1'b0; // [RULE16]
    end
  end

  // Air bit strobe for the radio core
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      air_cnt_q <= 13'h0000;
      air_tick  <= 1'b0;
    end else begin
      air_tick  <= air_cnt_q == 13'(AIR_DIV - 1); // [RULE18]
      air_cnt_q <= (air_cnt_q == 13'(AIR_DIV - 1))
                 ? 13'h0000 : air_cnt_q + 13'h0001;
    end
  end

  // Pin driven from buffer state; high during blackout
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) rts_n <= 1'b1;
    else rts_n <= boot_q || loaded_q[fptr_q]; // [RULE6]
  end

  // Byte at the current position of the response line
  assign last = 9'h005 + {6'h00, rsp_q.nval} + {1'b0, rsp_q.ndata};
  assign dpos = pos_q - 9'h004 - {6'h00, rsp_q.nval};
  always_comb begin
    if (pos_q == 9'h000) obyte = `RMC_CH_STAR; // [RULE2]
    else if (pos_q == 9'h001) obyte = rsp_q.n0;
    else if (pos_q == 9'h002) obyte = rsp_q.n1;
    else if (pos_q == 9'h003) obyte = `RMC_CH_EQ; // [RULE3]
    else if (pos_q < 9'h004 + {6'h00, rsp_q.nval})
      obyte = rsp_q.val[pos_q[1:0]];
    else if (pos_q < last - 9'h001) obyte = rf_rd_data;
    else if (pos_q == last - 9'h001) obyte = `RMC_CH_CR; // [RULE3]
    else obyte = `RMC_CH_LF;
  end

  // Response emitter; a command answer goes before a waiting report
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rsp_q        <= '0;
      act_q        <= 1'b0;
      is_cmd_q     <= 1'b0;
      gap_q        <= 1'b0;
      pos_q        <= 9'h000;
      ser_tx_valid <= 1'b0;
      ser_tx_data  <= 8'h00;
      rf_rx_ack    <= 1'b0;
      relay_fwd    <= 1'b0;
    end else begin
      rf_rx_ack <= 1'b0;
      relay_fwd <= 1'b0;
      if (cmd_take) begin
        act_q    <= 1'b1;
        is_cmd_q <= 1'b1;
        pos_q    <= 9'h000;
        gap_q    <= 1'b0;
        rsp_q.n0 <= bad_q ? `RMC_CH_E : n0_q; // [RULE4]
        rsp_q.n1 <= bad_q ? `RMC_CH_R : n1_q;
        rsp_q.val <= bad_q ? {16'h0000, `RMC_CH_1, `RMC_CH_0} : val_q;
        rsp_q.nval <= bad_q ? 3'h2 : nval_q;
        rsp_q.ndata <= 8'h00;
      end else if (!act_q && rf_rx_valid && !rf_rx_ack) begin
        if (rf_rx.err || rf_rx.relay) begin
          rf_rx_ack <= 1'b1; // [RULE12] [RULE19]
          relay_fwd <= rf_rx.relay && !rf_rx.err; // [RULE19]
        end else begin
          act_q    <= 1'b1;
          is_cmd_q <= 1'b0;
          pos_q    <= 9'h000;
          gap_q    <= 1'b0;
          rsp_q.n0 <= `RMC_CH_D;
          rsp_q.n1 <= (rf_rx.kind == 2'h1) ? `RMC_CH_C
                    : (rf_rx.kind == 2'h2) ? `RMC_CH_S : `RMC_CH_R; // [RULE17]
          rsp_q.val <= {16'h0000, hex_chr(rf_rx.len[3:0]),
                        hex_chr(rf_rx.len[7:4])};
          rsp_q.nval  <= 3'h2;
          rsp_q.ndata <= rf_rx.len;
        end
      end else if (act_q) begin
        if (ser_tx_valid) begin
          if (ser_tx_ready) begin
            ser_tx_valid <= 1'b0;
            gap_q        <= 1'b1; // Lets the radio read index settle
            pos_q        <= pos_q + 9'h001;
            if (pos_q == last) begin
              act_q     <= 1'b0;
              rf_rx_ack <= !is_cmd_q;
            end
          end
        end else if (gap_q) begin
          gap_q <= 1'b0;
        end else if (!cts_s2_q) begin
          ser_tx_valid <= 1'b1; // [RULE7]
          ser_tx_data  <= obyte;
        end
      end
    end
  end

  // Radio data read index follows the line position
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) rf_rd_idx <= 8'h00;
    else rf_rd_idx <= dpos[7:0];
  end

  sequence s_line_end;
    ser_tx_valid && act_q && pos_q == last;
  endsequence

  a_resp_star: assert property (@(posedge clk) disable iff (!nrst) // [RULE2]
    ser_tx_valid && act_q && pos_q == 9'h000 |-> ser_tx_data == `RMC_CH_STAR)
    else $error("response does not open with asterisk");
  a_resp_crlf: assert property (@(posedge clk) disable iff (!nrst) // [RULE3]
    s_line_end |-> ser_tx_data == `RMC_CH_LF)
    else $error("response does not close with line feed");
  a_one_answer: assert property (@(posedge clk) disable iff (!nrst) // [RULE4]
    cmd_req_q && !cmd_take |=> cmd_req_q)
    else $error("pending command response lost");
  a_cts_hold: assert property (@(posedge clk) disable iff (!nrst) // [RULE7]
    cts_s2_q && !ser_tx_valid |=> !ser_tx_valid)
    else $error("output started while clear to send is high");
  a_mode_pin: assert property (@(posedge clk) disable iff (!nrst) // [RULE8]
    mode_s2_q |=> mode_q == rmc_pkg::M_CMD)
    else $error("mode pin high did not restore command mode");
  a_esc_leave: assert property (@(posedge clk) disable iff (!nrst) // [RULE10]
    mode_q == rmc_pkg::M_TXT && rx_ok && rx_data == `RMC_CH_ESC
    |=> mode_q == rmc_pkg::M_CMD)
    else $error("escape did not leave text mode");
  a_boot_deaf: assert property (@(posedge clk) disable iff (!nrst) // [RULE11]
    boot_q |-> rts_n && pst_q == rmc_pkg::P_IDLE && !wr_en)
    else $error("input accepted during power-up blackout");
  a_err_drop: assert property (@(posedge clk) disable iff (!nrst) // [RULE12]
    !act_q && !cmd_req_q && rf_rx_valid && !rf_rx_ack && rf_rx.err
    |=> rf_rx_ack && !act_q ##1 !(act_q && !is_cmd_q))
    else $error("errored frame was reported");
  a_tx_launch: assert property (@(posedge clk) disable iff (!nrst) // [RULE15]
    rf_tx_start |-> tx_mode && busy_q)
    else $error("radio started without transmit mode");
  a_win_hold: assert property (@(posedge clk) disable iff (!nrst) // [RULE16]
    tx_mode && win_q != 24'h000000 |=> tx_mode)
    else $error("left transmit inside the continuous window");
  a_air_rate: assert property (@(posedge clk) disable iff (!nrst) // [RULE18]
    air_tick |=> !air_tick [*8])
    else $error("air strobe faster than divider");

endmodule

`default_nettype wire

// [hw/rmc_defs.svh]
// Constants of the radio modem host command port
`ifndef RMC_DEFS_SVH
`define RMC_DEFS_SVH

// Framing characters
`define RMC_CH_PFX    8'h40
`define RMC_CH_CR     8'h0d
`define RMC_CH_LF     8'h0a
`define RMC_CH_STAR   8'h2a
`define RMC_CH_EQ     8'h3d
`define RMC_CH_ESC    8'h1b
`define RMC_CH_SP     8'h20
`define RMC_CH_D      8'h44
`define RMC_CH_T      8'h54
`define RMC_CH_M      8'h4d
`define RMC_CH_B      8'h42
`define RMC_CH_I      8'h49
`define RMC_CH_X      8'h58
`define RMC_CH_E      8'h45
`define RMC_CH_R      8'h52
`define RMC_CH_C      8'h43
`define RMC_CH_S      8'h53
`define RMC_CH_0      8'h30
`define RMC_CH_1      8'h31

// Sizes
`define RMC_BUF_DEPTH 255
`define RMC_VAL_MAX   4

// Times in their own units
`define RMC_CLK_HZ       25000000
`define RMC_BOOT_MS      100
`define RMC_WIN_BASE_US  5000
`define RMC_WIN_BYTE_US  2080
`define RMC_AIR_BPS      4800

// Derived cycle counts
`define RMC_BOOT_CYC     ((`RMC_CLK_HZ / 1000) * `RMC_BOOT_MS)
`define RMC_WIN_BASE_CYC ((`RMC_CLK_HZ / 1000000) * `RMC_WIN_BASE_US)
`define RMC_WIN_BYTE_CYC ((`RMC_CLK_HZ / 1000000) * `RMC_WIN_BYTE_US)
`define RMC_AIR_DIV      (`RMC_CLK_HZ / `RMC_AIR_BPS)

`endif

// [hw/rmc_pkg.sv]
// Types of the radio modem host command port
package rmc_pkg;

  // Operating mode
  typedef enum logic [1:0] {
    M_CMD = 2'h0,
    M_TXT = 2'h1,
    M_BIN = 2'h3
  } rmc_mode_e;

  // Command line parser, Gray in listed order
  typedef enum logic [2:0] {
    P_IDLE = 3'h0,
    P_N0   = 3'h1,
    P_N1   = 3'h3,
    P_ARG  = 3'h2,
    P_CNT  = 3'h6,
    P_SEP  = 3'h7,
    P_PAY  = 3'h5,
    P_END  = 3'h4
  } rmc_pst_e;

  // Received radio frame descriptor
  typedef struct packed {
    logic       err;   // Radio check failed
    logic       relay; // Not addressed to us
    logic [1:0] kind;  // 0 plain, 1 variant c, 2 variant s
    logic [7:0] len;   // Payload bytes
  } rmc_rfi_s;

  // One response line
  typedef struct packed {
    logic [7:0]      n0;
    logic [7:0]      n1;
    logic [3:0][7:0] val;
    logic [2:0]      nval;
    logic [7:0]      ndata;
  } rmc_rsp_s;

endpackage

// [testbench/rmc_host_model.sv]
// Host controller model: serial sink that stalls and drives the CTS pin
`timescale 1ns/1ps
`default_nettype none

module rmc_host_model (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       nrst,
  // Device serial output
  input  wire logic       ser_tx_valid,
  input  wire logic [7:0] ser_tx_data,
  output logic            ser_tx_ready,
  // Flow control
  input  wire logic       hold,
  output logic            cts_n,
  // Bytes taken
  output logic            got,
  output logic [7:0]      got_b
);
  logic [1:0] ph_q; // Stall phase

  // Refuse one cycle in three, so the device never sees an ideal host
  always_ff @(negedge clk or negedge nrst) begin
    if (!nrst) begin
      ph_q <= 2'h0;
    end else begin
      ph_q <= (ph_q == 2'h2) ? 2'h0 : ph_q + 2'h1;
    end
  end

  assign ser_tx_ready = (ph_q != 2'h0);
  assign cts_n        = hold; // Raising CTS stops device output
  assign got          = ser_tx_valid & ser_tx_ready;
  assign got_b        = ser_tx_data;
endmodule

`default_nettype wire

// [testbench/radio_modem_host_command_port_bench.sv]
// Self-checking bench of the radio modem host command port
`timescale 1ns/1ps
`default_nettype none

module radio_modem_host_command_port_bench;
  logic              clk = 1'b0, nrst = 1'b0, rx_valid = 1'b0, mode_pin = 1'b1;
  logic [7:0]        rx_data = 8'h00, rf_rd_idx, rf_tx_len, rf_tx_data, got_b;
  logic              ser_tx_valid, ser_tx_ready, rts_n, cts_n, hold = 1'b0, got;
  logic [7:0]        ser_tx_data, rf_rd_data, st_len, st_dat, r0;
  logic              rf_rx_valid = 1'b0, rf_rx_ack, relay_fwd, rf_tx_start, rf_tx_sel;
  logic              rf_tx_done = 1'b0, tx_mode, air_tick, st_sel, st_mode, fwd;
  rmc_pkg::rmc_rfi_s rf_rx = '0;
  logic [7:0]        exp_q[$];     // Expected serial bytes, oldest first
  int                error_cnt = 0, compares = 0, seed = 80103;
  int                st_cnt = 0, dcnt = 0, acnt = 0, n, k, m;
  bit                aseen = 1'b0;
  string             nm = "RCS";   // Report name letters by frame kind

  always #20 clk = ~clk;
  assign rf_rd_data = 8'h61 + rf_rd_idx; // Radio payload byte i is 'a'+i

  rmc_port #(.BOOT_CYC(20), .WIN_BASE(10), .WIN_BYTE(2), .AIR_DIV(12)) rmc_port_i (
    .clk(clk), .nrst(nrst), .rx_valid(rx_valid), .rx_data(rx_data),
    .ser_tx_valid(ser_tx_valid), .ser_tx_data(ser_tx_data), .ser_tx_ready(ser_tx_ready),
    .rts_n(rts_n), .cts_n(cts_n), .mode_pin(mode_pin), .rf_rx_valid(rf_rx_valid),
    .rf_rx(rf_rx), .rf_rx_ack(rf_rx_ack), .relay_fwd(relay_fwd), .rf_rd_idx(rf_rd_idx),
    .rf_rd_data(rf_rd_data), .rf_tx_start(rf_tx_start), .rf_tx_sel(rf_tx_sel),
    .rf_tx_len(rf_tx_len), .rf_tx_rd_idx(8'h00), .rf_tx_data(rf_tx_data),
    .rf_tx_done(rf_tx_done), .tx_mode(tx_mode), .air_tick(air_tick));

  rmc_host_model rmc_host_model_i (
    .clk(clk), .nrst(nrst), .ser_tx_valid(ser_tx_valid), .ser_tx_data(ser_tx_data),
    .ser_tx_ready(ser_tx_ready), .hold(hold), .cts_n(cts_n), .got(got), .got_b(got_b));

  // Verdict and end of run
  task automatic test_done;
    $display("checks %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // Byte compare
  task automatic chk_b(input logic [7:0] e, input logic [7:0] a);
    compares++;
    if (a !== e) begin
      error_cnt++;
      $display("MISMATCH %0t byte got %h want %h", $time, a, e);
    end
  endtask

  // Bit compare
  task automatic chk_1(input logic e, input logic a);
    compares++;
    if (a !== e) begin
      error_cnt++;
      $display("MISMATCH %0t flag got %b want %b", $time, a, e);
    end
  endtask

  // One host byte, a single-cycle strobe
  task automatic txb(input logic [7:0] b);
    @(negedge clk) rx_valid = 1'b1;
    rx_data = b;
    @(negedge clk) rx_valid = 1'b0;
  endtask

  task automatic tx(input string s);
    for (int i = 0; i < s.len(); i++) txb(s[i]);
  endtask

  task automatic put(input string s);
    for (int i = 0; i < s.len(); i++) exp_q.push_back(s[i]);
  endtask

  // Host waits for the whole answer before its next line
  task automatic wait_q;
    for (int i = 0; i < 3000 && exp_q.size() != 0; i++) @(negedge clk);
    if (exp_q.size() != 0) begin
      error_cnt++;
      $display("MISMATCH %0t answer not complete in time", $time);
      test_done;
    end
  endtask

  // Radio frame held until consumed; relay flag taken with the ack
  task automatic frame(input logic e, input logic r, input logic [1:0] kd);
    int i;
    @(negedge clk) rf_rx_valid = 1'b1;
    rf_rx = '{err: e, relay: r, kind: kd, len: 8'h02};
    for (i = 0; i < 600 && rf_rx_ack !== 1'b1; i++) @(negedge clk);
    fwd = relay_fwd;
    rf_rx_valid = 1'b0;
    if (i == 600) begin
      error_cnt++;
      $display("MISMATCH %0t frame never consumed", $time);
      test_done;
    end
  endtask

  // Watcher: every byte the host takes is matched to the oldest note; a byte with none noted is an error
  always @(posedge clk) begin
    if (nrst && got) begin
      if (exp_q.size() == 0) begin
        error_cnt++;
        $display("MISMATCH %0t unexpected byte %h", $time, got_b);
      end else begin
        chk_b(exp_q.pop_front(), got_b);
      end
    end
  end

  // Radio core stand-in: capture each launch, report done five cycles on
  always @(posedge clk) begin
    if (rf_tx_start) begin
      st_cnt++;
      dcnt = 5;
    end else if (dcnt > 0) begin
      dcnt--;
    end
    if (dcnt == 4) begin
      st_sel = rf_tx_sel;
      st_len = rf_tx_len;
      st_mode = tx_mode;
    end
    if (dcnt == 2) st_dat = rf_tx_data;
    acnt++;
    if (air_tick) begin
      if (aseen) chk_b(8'h0c, 8'(acnt));
      acnt = 0;
      aseen = 1'b1;
    end
  end
  always @(negedge clk) rf_tx_done <= (dcnt == 1);

  // Main sequence
  initial begin
    repeat (5) @(negedge clk);
    nrst = 1'b1;
    tx("@XY\r");                          // Dropped during blackout
    chk_1(1'b1, rts_n);
    for (int i = 0; i < 40 && rts_n !== 1'b0; i++) @(negedge clk);
    chk_1(1'b0, rts_n);
    put("*CH=03\r\n"); tx("@CH 03\r"); wait_q;
    put("*ER=01\r\n"); tx("@C\r"); wait_q;
    hold = 1'b1;
    put("*CH=07\r\n");
    n = exp_q.size();                     // Nothing may leave while CTS is high
    tx("@CH 07\r");
    repeat (30) @(negedge clk);
    chk_b(8'(n), 8'(exp_q.size()));
    hold = 1'b0; wait_q;
    for (k = 0; k < 2; k++) begin
      r0 = 8'($random(seed));
      n = st_cnt;
      put("*DT=02\r\n");
      tx("@DT 02 ");
      txb(r0);
      txb(8'($random(seed)));
      txb(8'h0d);
      wait_q;                             // Answer doubles as the acknowledge
      chk_b(8'(n + 1), 8'(st_cnt));
      chk_1(k[0], st_sel);
      chk_b(8'h02, st_len);
      chk_b(r0, st_dat);
      chk_1(1'b1, st_mode);
    end
    frame(1'b1, 1'b0, 2'h0); chk_1(1'b0, fwd);
    frame(1'b0, 1'b1, 2'h0); chk_1(1'b1, fwd);
    for (k = 0; k < 3; k++) begin
      put("*D"); exp_q.push_back(nm[k]); put("=02ab\r\n");
      frame(1'b0, 1'b0, 2'(k)); wait_q;
    end
    for (m = 0; m < 2; m++) begin
      put(m ? "*MD=BI\r\n" : "*MD=TX\r\n"); tx(m ? "@MD BI\r" : "@MD TX\r"); wait_q;
      mode_pin = 1'b0;
      repeat (5) @(negedge clk);
      n = st_cnt;
      txb(8'h7a);                         // One data byte into the free buffer
      if (m == 0) txb(8'h1b);             // Escape leaves text mode
      mode_pin = (m == 1);                // Pin rise leaves binary mode
      repeat (12) @(negedge clk);
      chk_b(8'(n + 1), 8'(st_cnt));
      chk_b(8'h7a, st_dat);
      put("*CH=05\r\n"); tx("@CH 05\r"); wait_q;
      mode_pin = 1'b1;
    end
    repeat (40) @(negedge clk);
    chk_1(1'b0, tx_mode);
    test_done;
  end
endmodule

`default_nettype wire
